// ---- shared/dfm_pkg.sv ----
/*
  dfm_pkg: register offsets, field positions, reset values, format codes
  and carrier types for the format, operation and soft-mute controls.
  Assumes an 8-bit register port whose address is the 7-bit control index.
*/
package dfm_pkg;

  // ------------------------------------------------------------
  // geometry
  // ------------------------------------------------------------
  localparam int NUM_CH = 8;
  localparam int NUM_PAIR = 4;
  localparam int ADDR_W = 7;
  localparam int DATA_W = 8;
  localparam int ATT_W = 8;

  // ------------------------------------------------------------
  // register offsets
  // ------------------------------------------------------------
  localparam logic [ADDR_W-1:0] ADDR_FORMAT_POWERSAVE = 7'h41;
  localparam logic [ADDR_W-1:0] ADDR_OPERATION_FILTER = 7'h42;
  localparam logic [ADDR_W-1:0] ADDR_OUTPUT_PHASE = 7'h43;
  localparam logic [ADDR_W-1:0] ADDR_SOFT_MUTE = 7'h44;

  // ------------------------------------------------------------
  // field positions
  // ------------------------------------------------------------
  localparam int PSEL_BIT = 7;
  localparam int FMT_LSB = 0;
  localparam int FMT_MSB = 3;
  localparam int FLT_LSB = 0;
  localparam int FLT_MSB = 3;
  localparam int OPE_LSB = 4;
  localparam int OPE_MSB = 7;

  // ------------------------------------------------------------
  // reset values
  // ------------------------------------------------------------
  localparam logic RST_PSEL = 1'b0;
  localparam logic [3:0] RST_FMT = 4'h0;
  localparam logic [3:0] RST_OPE = 4'h0;
  localparam logic [3:0] RST_FLT = 4'h0;
  localparam logic [7:0] RST_PHASE = 8'h00;
  localparam logic [7:0] RST_MUTE = 8'h00;
  localparam logic [7:0] RST_RDATA = 8'h00;
  localparam logic [ATT_W-1:0] RST_ATT = 8'h00;
  localparam logic [ATT_W-1:0] ATT_INF = 8'hFF;  // infinite attenuation code
  localparam logic [ATT_W-1:0] ATT_STEP = 8'h01;

  // ------------------------------------------------------------
  // interface format codes
  // ------------------------------------------------------------
  typedef enum logic [3:0] {
    FMT_I2S = 4'h0,
    FMT_LEFT_JUST = 4'h1,
    FMT_RIGHT_24 = 4'h2,
    FMT_RIGHT_16 = 4'h3,
    FMT_DSP_I2S = 4'h4,
    FMT_DSP_LEFT = 4'h5,
    FMT_TDM_I2S = 4'h6,
    FMT_TDM_LEFT = 4'h7,
    FMT_TDM_HS_I2S = 4'h8,
    FMT_TDM_HS_LEFT = 4'h9
  } dfm_format_t;

  // per-pair controls into the converter datapath
  typedef struct packed {
    logic [NUM_PAIR-1:0] disabled;      // cut from serial input, data reset
    logic [NUM_PAIR-1:0] common_mode;   // output forced to common_mode_level
    logic [NUM_PAIR-1:0] analog_ground; // output forced to analog_ground
    logic [NUM_PAIR-1:0] power_down;
    logic [NUM_PAIR-1:0] slow_rolloff;
  } dfm_pair_ctrl_t;

  // decoded format flags
  typedef struct packed {
    logic [3:0] code;
    logic dsp;
    logic tdm;
    logic high_speed;
    logic left_align;
  } dfm_fmt_info_t;

endpackage : dfm_pkg

// ---- rtl/dfm_ctrl_regs.sv ----
/*
  dfm_ctrl_regs: format/power-save, operation/filter, output phase and
  soft-mute control registers, plus the per-channel soft-mute attenuator ramp.
  Assumes the serial control decoder, attenuation level registers, sample tick
  and analog-mute enable all run on clk_i; no synchronisers are needed.
*/
`timescale 1ns/10ps
module dfm_ctrl_regs (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wr_en_i,
  input wire logic rd_en_i,
  input wire logic [6:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic fs_tick_i,
  input wire logic analog_mute_ctrl_on_disable_i,
  input wire logic [63:0] atten_level_i,
  output logic [7:0] rdata_o,
  output logic power_save_select_o,
  output dfm_pkg::dfm_fmt_info_t iface_format_sel_o,
  output dfm_pkg::dfm_pair_ctrl_t pair_ctrl_o,
  output logic [7:0] output_invert_o,
  output logic [7:0] soft_mute_en_o,
  output logic [63:0] atten_now_o,
  output logic [3:0] analog_mute_ctrl_o
);

  // ------------------------------------------------------------
  // register storage
  // ------------------------------------------------------------
  logic psel_reg;
  logic [3:0] fmt_reg;
  logic [3:0] ope_reg;
  logic [3:0] flt_reg;
  logic [7:0] phase_reg;
  logic [7:0] mute_reg;
  logic [7:0] att_reg [dfm_pkg::NUM_CH];
  logic [7:0] rdata_next;

  // write strobes per register
  logic wr_fmt;
  logic wr_ope;
  logic wr_phase;
  logic wr_mute;

  assign wr_fmt = wr_en_i && (addr_i == dfm_pkg::ADDR_FORMAT_POWERSAVE);
  assign wr_ope = wr_en_i && (addr_i == dfm_pkg::ADDR_OPERATION_FILTER);
  assign wr_phase = wr_en_i && (addr_i == dfm_pkg::ADDR_OUTPUT_PHASE);
  assign wr_mute = wr_en_i && (addr_i == dfm_pkg::ADDR_SOFT_MUTE);

  // ------------------------------------------------------------
  // format and power-save register
  // ------------------------------------------------------------
  // reserved bits are not stored and read back zero
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      psel_reg <= dfm_pkg::RST_PSEL;
      fmt_reg <= dfm_pkg::RST_FMT;
    end else if (wr_fmt) begin
      psel_reg <= wdata_i[dfm_pkg::PSEL_BIT];
      fmt_reg <= wdata_i[dfm_pkg::FMT_MSB:dfm_pkg::FMT_LSB];
    end
  end

  // ------------------------------------------------------------
  // operation and roll-off register
  // ------------------------------------------------------------
  // accepted regardless of any pair being disabled
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      ope_reg <= dfm_pkg::RST_OPE;
      flt_reg <= dfm_pkg::RST_FLT;
    end else if (wr_ope) begin
      ope_reg <= wdata_i[dfm_pkg::OPE_MSB:dfm_pkg::OPE_LSB];
      flt_reg <= wdata_i[dfm_pkg::FLT_MSB:dfm_pkg::FLT_LSB];
    end
  end

  // ------------------------------------------------------------
  // phase and soft-mute registers
  // ------------------------------------------------------------
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      phase_reg <= dfm_pkg::RST_PHASE;
    end else if (wr_phase) begin
      phase_reg <= wdata_i;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      mute_reg <= dfm_pkg::RST_MUTE;
    end else if (wr_mute) begin
      mute_reg <= wdata_i;
    end
  end

  // ------------------------------------------------------------
  // read-back
  // ------------------------------------------------------------
  // unmapped addresses read zero
  always_comb begin
    rdata_next = dfm_pkg::RST_RDATA;
    case (addr_i)
      dfm_pkg::ADDR_FORMAT_POWERSAVE: begin
        rdata_next[dfm_pkg::PSEL_BIT] = psel_reg;
        rdata_next[dfm_pkg::FMT_MSB:dfm_pkg::FMT_LSB] = fmt_reg;
      end
      dfm_pkg::ADDR_OPERATION_FILTER: begin
        rdata_next = {ope_reg, flt_reg};
      end
      dfm_pkg::ADDR_OUTPUT_PHASE: begin
        rdata_next = phase_reg;
      end
      dfm_pkg::ADDR_SOFT_MUTE: begin
        rdata_next = mute_reg;
      end
      default: begin
        rdata_next = dfm_pkg::RST_RDATA;
      end
    endcase
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      rdata_o <= dfm_pkg::RST_RDATA;
    end else if (rd_en_i) begin
      rdata_o <= rdata_next;
    end
  end

  // ------------------------------------------------------------
  // format decode
  // ------------------------------------------------------------
  // reserved codes are passed through without any flag set
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      iface_format_sel_o <= '0;
    end else begin
      iface_format_sel_o.code <= fmt_reg;
      iface_format_sel_o.dsp <= (fmt_reg == dfm_pkg::FMT_DSP_I2S) || (fmt_reg == dfm_pkg::FMT_DSP_LEFT);
      iface_format_sel_o.tdm <= (fmt_reg == dfm_pkg::FMT_TDM_I2S) || (fmt_reg == dfm_pkg::FMT_TDM_LEFT)
                                || (fmt_reg == dfm_pkg::FMT_TDM_HS_I2S)
                                || (fmt_reg == dfm_pkg::FMT_TDM_HS_LEFT);
      iface_format_sel_o.high_speed <= (fmt_reg == dfm_pkg::FMT_TDM_HS_I2S)
                                       || (fmt_reg == dfm_pkg::FMT_TDM_HS_LEFT);
      iface_format_sel_o.left_align <= (fmt_reg == dfm_pkg::FMT_LEFT_JUST) || (fmt_reg == dfm_pkg::FMT_DSP_LEFT)
                                       || (fmt_reg == dfm_pkg::FMT_TDM_LEFT)
                                       || (fmt_reg == dfm_pkg::FMT_TDM_HS_LEFT);
    end
  end

  // ------------------------------------------------------------
  // pair controls and channel outputs
  // ------------------------------------------------------------
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      pair_ctrl_o <= '0;
      power_save_select_o <= dfm_pkg::RST_PSEL;
      analog_mute_ctrl_o <= dfm_pkg::RST_OPE;
    end else begin
      power_save_select_o <= psel_reg;
      pair_ctrl_o.disabled <= ope_reg;
      pair_ctrl_o.common_mode <= ope_reg & {dfm_pkg::NUM_PAIR{psel_reg}};
      pair_ctrl_o.analog_ground <= ope_reg & {dfm_pkg::NUM_PAIR{~psel_reg}};
      pair_ctrl_o.power_down <= ope_reg & {dfm_pkg::NUM_PAIR{~psel_reg}};
      pair_ctrl_o.slow_rolloff <= flt_reg;
      analog_mute_ctrl_o <= ope_reg & {dfm_pkg::NUM_PAIR{analog_mute_ctrl_on_disable_i}};
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      output_invert_o <= dfm_pkg::RST_PHASE;
      soft_mute_en_o <= dfm_pkg::RST_MUTE;
    end else begin
      output_invert_o <= phase_reg;
      soft_mute_en_o <= mute_reg;
    end
  end

  // ------------------------------------------------------------
  // soft-mute attenuator ramp
  // ------------------------------------------------------------
  // one step per sample tick toward mute or the programmed level
  genvar ch;
  generate
    for (ch = 0; ch < dfm_pkg::NUM_CH; ch++) begin : g_ramp
      logic [7:0] target;
      assign target = mute_reg[ch] ? dfm_pkg::ATT_INF : atten_level_i[ch*dfm_pkg::ATT_W +: dfm_pkg::ATT_W];
      always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
          att_reg[ch] <= dfm_pkg::RST_ATT;
        end else if (fs_tick_i) begin
          if (att_reg[ch] < target) begin
            att_reg[ch] <= 8'(att_reg[ch] + dfm_pkg::ATT_STEP);
          end else if (att_reg[ch] > target) begin
            att_reg[ch] <= 8'(att_reg[ch] - dfm_pkg::ATT_STEP);
          end
        end
      end
      assign atten_now_o[ch*dfm_pkg::ATT_W +: dfm_pkg::ATT_W] = att_reg[ch];

      // muted channel never moves toward less attenuation
      a_mute_no_rise: assert property (@(posedge clk_i) disable iff (rst_i)
        mute_reg[ch] && !wr_mute |=> att_reg[ch] >= $past(att_reg[ch]))
        else $error("muted channel attenuation fell");

      // unmuted channel above level steps down by one on a tick
      a_unmute_step: assert property (@(posedge clk_i) disable iff (rst_i)
        !mute_reg[ch] && fs_tick_i && att_reg[ch] > target |=> att_reg[ch] == $past(att_reg[ch]) - 8'h01)
        else $error("unmute ramp step wrong");

      // attenuation only moves on a sample tick
      a_ramp_tick: assert property (@(posedge clk_i) disable iff (rst_i)
        !fs_tick_i |=> $stable(att_reg[ch]))
        else $error("attenuation moved without tick");

      // mute overrides a lower programmed level
      a_mute_override: assert property (@(posedge clk_i) disable iff (rst_i)
        mute_reg[ch] && fs_tick_i && att_reg[ch] != dfm_pkg::ATT_INF
        |=> att_reg[ch] == $past(att_reg[ch]) + 8'h01)
        else $error("mute did not override level");

      // a fully muted channel stays at infinite attenuation
      a_mute_at_inf: assert property (@(posedge clk_i) disable iff (rst_i)
        mute_reg[ch] && att_reg[ch] == dfm_pkg::ATT_INF |=> att_reg[ch] == dfm_pkg::ATT_INF)
        else $error("muted channel left infinite attenuation");
    end
  endgenerate

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  a_psel_store: assert property (@(posedge clk_i) disable iff (rst_i)
    wr_fmt |=> ##1 power_save_select_o == $past(wdata_i[dfm_pkg::PSEL_BIT], 2))
    else $error("power-save select not stored");

  a_fmt_store: assert property (@(posedge clk_i) disable iff (rst_i)
    wr_fmt |=> ##1 iface_format_sel_o.code == $past(wdata_i[3:0], 2))
    else $error("format code not stored");

  a_tdm_flag: assert property (@(posedge clk_i) disable iff (rst_i)
    fmt_reg == dfm_pkg::FMT_TDM_HS_LEFT |=> iface_format_sel_o.tdm && iface_format_sel_o.high_speed)
    else $error("high-speed tdm not decoded");

  a_common_mode_level_force: assert property (@(posedge clk_i) disable iff (rst_i)
    psel_reg |=> pair_ctrl_o.common_mode == $past(ope_reg) && pair_ctrl_o.power_down == 4'h0)
    else $error("common-mode force wrong");

  a_analog_ground_force: assert property (@(posedge clk_i) disable iff (rst_i)
    !psel_reg |=> pair_ctrl_o.analog_ground == $past(ope_reg) && pair_ctrl_o.power_down == $past(ope_reg))
    else $error("ground force or power down wrong");

  a_write_while_off: assert property (@(posedge clk_i) disable iff (rst_i)
    ope_reg != 4'h0 && wr_mute |=> mute_reg == $past(wdata_i))
    else $error("write lost while pair disabled");

  a_pair_disable: assert property (@(posedge clk_i) disable iff (rst_i)
    wr_ope |=> ##1 pair_ctrl_o.disabled == $past(wdata_i[7:4], 2))
    else $error("pair disable not applied");

  a_invert_map: assert property (@(posedge clk_i) disable iff (rst_i)
    wr_phase |=> ##1 output_invert_o == $past(wdata_i, 2))
    else $error("invert bits not applied");

  a_analog_mute_ctrl_link: assert property (@(posedge clk_i) disable iff (rst_i)
    analog_mute_ctrl_on_disable_i && ope_reg != 4'h0 |=> analog_mute_ctrl_o != 4'h0)
    else $error("analog mute not engaged");

  // no analog mute request while the disable source is off
  a_analog_mute_ctrl_off: assert property (@(posedge clk_i) disable iff (rst_i)
    !analog_mute_ctrl_on_disable_i |=> analog_mute_ctrl_o == 4'h0)
    else $error("analog mute engaged while source off");

  // roll-off bits reach the pair controls
  a_rolloff_map: assert property (@(posedge clk_i) disable iff (rst_i)
    wr_ope |=> ##1 pair_ctrl_o.slow_rolloff == $past(wdata_i[3:0], 2))
    else $error("roll-off bits not applied");

  // soft-mute bits reach their output copy
  a_mute_map: assert property (@(posedge clk_i) disable iff (rst_i)
    wr_mute |=> ##1 soft_mute_en_o == $past(wdata_i, 2))
    else $error("soft-mute bits not applied");

  // disabled pairs follow the operation bits
  a_disable_copy: assert property (@(posedge clk_i) disable iff (rst_i)
    ope_reg != 4'h0 |=> pair_ctrl_o.disabled == $past(ope_reg))
    else $error("disabled pairs wrong");

  // power-save mode never forces common-mode level
  a_psel_ground: assert property (@(posedge clk_i) disable iff (rst_i)
    !psel_reg |=> pair_ctrl_o.common_mode == 4'h0)
    else $error("common-mode forced in power-save mode");

  // dsp left-justified code decodes to dsp with left alignment
  a_dsp_flag: assert property (@(posedge clk_i) disable iff (rst_i)
    fmt_reg == dfm_pkg::FMT_DSP_LEFT |=> iface_format_sel_o.dsp && iface_format_sel_o.left_align
    && !iface_format_sel_o.tdm)
    else $error("dsp format not decoded");

  // 16-bit right-justified code raises no flag
  a_right_flags: assert property (@(posedge clk_i) disable iff (rst_i)
    fmt_reg == dfm_pkg::FMT_RIGHT_16 |=> !iface_format_sel_o.dsp && !iface_format_sel_o.tdm
    && !iface_format_sel_o.high_speed && !iface_format_sel_o.left_align)
    else $error("right-justified format flags wrong");

  // format register read-back, reserved bits zero
  a_read_format: assert property (@(posedge clk_i) disable iff (rst_i)
    rd_en_i && addr_i == dfm_pkg::ADDR_FORMAT_POWERSAVE |=> rdata_o == {$past(psel_reg), 3'b000, $past(fmt_reg)})
    else $error("format register read wrong");

  // operation and roll-off read-back
  a_read_opflt: assert property (@(posedge clk_i) disable iff (rst_i)
    rd_en_i && addr_i == dfm_pkg::ADDR_OPERATION_FILTER |=> rdata_o == {$past(ope_reg), $past(flt_reg)})
    else $error("operation register read wrong");

  // phase read-back
  a_read_phase: assert property (@(posedge clk_i) disable iff (rst_i)
    rd_en_i && addr_i == dfm_pkg::ADDR_OUTPUT_PHASE |=> rdata_o == $past(phase_reg))
    else $error("phase register read wrong");

  // soft-mute read-back
  a_read_mute: assert property (@(posedge clk_i) disable iff (rst_i)
    rd_en_i && addr_i == dfm_pkg::ADDR_SOFT_MUTE |=> rdata_o == $past(mute_reg))
    else $error("soft-mute register read wrong");

endmodule : dfm_ctrl_regs

// ---- verification/dac_format_operation_mute_ctrl_test.sv ----
/*
  dac_format_operation_mute_ctrl_test: self-checking bench for dfm_ctrl_regs.
  Assumes dfm_pkg is compiled first; the bench drives the register port itself.
*/
`timescale 1ns/10ps
module dac_format_operation_mute_ctrl_test;
  // ------------------------------------------------------------
  // stimulus, outputs and model state
  // ------------------------------------------------------------
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wr_en_i = 1'b0;
  logic rd_en_i = 1'b0;
  logic [6:0] addr_i = 7'h00;
  logic [7:0] wdata_i = 8'h00;
  logic fs_tick_i = 1'b0;
  logic analog_mute_ctrl_on_disable_i = 1'b0;
  logic [63:0] atten_level_i = 64'h0000_0000_0000_0000;
  logic [7:0] rdata_o;
  logic power_save_select_o;
  dfm_pkg::dfm_fmt_info_t iface_format_sel_o;
  dfm_pkg::dfm_pair_ctrl_t pair_ctrl_o;
  logic [7:0] output_invert_o;
  logic [7:0] soft_mute_en_o;
  logic [63:0] atten_now_o;
  logic [3:0] analog_mute_ctrl_o;
  int err_count = 0;
  int comparisons = 0;
  int cycles = 0;
  logic psel;
  logic [3:0] fmt, ope, filter_rolloff_sel;
  logic [7:0] ph, mu;
  int att[8];

  dfm_ctrl_regs i_dut (.clk_i(clk_i), .rst_i(rst_i), .wr_en_i(wr_en_i), .rd_en_i(rd_en_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .fs_tick_i(fs_tick_i), .analog_mute_ctrl_on_disable_i(analog_mute_ctrl_on_disable_i),
    .atten_level_i(atten_level_i), .rdata_o(rdata_o), .power_save_select_o(power_save_select_o),
    .iface_format_sel_o(iface_format_sel_o), .pair_ctrl_o(pair_ctrl_o), .output_invert_o(output_invert_o),
    .soft_mute_en_o(soft_mute_en_o), .atten_now_o(atten_now_o), .analog_mute_ctrl_o(analog_mute_ctrl_o));

  // 50 ns clock
  initial begin
    forever #25 clk_i = ~clk_i;
  end

  // hang guard
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 10000) begin
      err_count++;
      $display("[FAIL] timeout expected done seen hang");
      final_report();
    end
  end

  task automatic final_report();
    $display("comparisons %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : final_report

  task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // decoded format flags from the model code
  function automatic logic [7:0] fmt_exp();
    logic dsp, tdm, hs, la;
    dsp = (fmt == 4'h4) || (fmt == 4'h5);
    tdm = (fmt >= 4'h6) && (fmt <= 4'h9);
    hs = (fmt == 4'h8) || (fmt == 4'h9);
    la = fmt[0] && (fmt <= 4'h9) && (fmt != 4'h3);
    return {fmt, dsp, tdm, hs, la};
  endfunction : fmt_exp

  task automatic check_outs();
    logic [3:0] ps;
    ps = {4{psel}};
    chk("power_save_select_o", 64'(psel), 64'(power_save_select_o));
    chk("iface_format_sel_o", 64'(fmt_exp()), 64'(iface_format_sel_o));
    chk("pair_ctrl_o", 64'({ope, ope & ps, ope & ~ps, ope & ~ps, filter_rolloff_sel}), 64'(pair_ctrl_o));
    chk("analog_mute_ctrl_o", 64'(ope & {4{analog_mute_ctrl_on_disable_i}}), 64'(analog_mute_ctrl_o));
    chk("output_invert_o", 64'(ph), 64'(output_invert_o));
    chk("soft_mute_en_o", 64'(mu), 64'(soft_mute_en_o));
  endtask : check_outs

  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    @(posedge clk_i);
    wr_en_i <= 1'b1;
    addr_i <= a;
    wdata_i <= d;
    @(posedge clk_i);
    wr_en_i <= 1'b0;
    if (a == dfm_pkg::ADDR_FORMAT_POWERSAVE) begin
      psel = d[7];
      fmt = d[3:0];
    end
    if (a == dfm_pkg::ADDR_OPERATION_FILTER) begin
      ope = d[7:4];
      filter_rolloff_sel = d[3:0];
    end
    if (a == dfm_pkg::ADDR_OUTPUT_PHASE) ph = d;
    if (a == dfm_pkg::ADDR_SOFT_MUTE) mu = d;
    repeat (2) @(posedge clk_i);
    #1;
  endtask : wr

  task automatic rd_chk(input logic [6:0] a);
    logic [7:0] e;
    e = 8'h00;
    if (a == dfm_pkg::ADDR_FORMAT_POWERSAVE) e = {psel, 3'b000, fmt};
    if (a == dfm_pkg::ADDR_OPERATION_FILTER) e = {ope, filter_rolloff_sel};
    if (a == dfm_pkg::ADDR_OUTPUT_PHASE) e = ph;
    if (a == dfm_pkg::ADDR_SOFT_MUTE) e = mu;
    @(posedge clk_i);
    rd_en_i <= 1'b1;
    addr_i <= a;
    @(posedge clk_i);
    rd_en_i <= 1'b0;
    @(posedge clk_i);
    #1;
    chk("rdata_o", 64'(e), 64'(rdata_o));
  endtask : rd_chk

  // one sample period: each attenuator steps once toward its target
  task automatic tick();
    int t;
    logic [63:0] p;
    @(posedge clk_i);
    fs_tick_i <= 1'b1;
    @(posedge clk_i);
    fs_tick_i <= 1'b0;
    #1;
    for (int c = 0; c < 8; c++) begin
      t = mu[c] ? 255 : int'(atten_level_i[c*8 +: 8]);
      if (att[c] < t) att[c]++;
      else if (att[c] > t) att[c]--;
      p[c*8 +: 8] = 8'(att[c]);
    end
    chk("atten_now_o", p, atten_now_o);
  endtask : tick

  task automatic do_reset();
    @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    psel = 1'b0;
    fmt = 4'h0;
    ope = 4'h0;
    filter_rolloff_sel = 4'h0;
    ph = 8'h00;
    mu = 8'h00;
    foreach (att[c]) att[c] = 0;
    repeat (2) @(posedge clk_i);
    #1;
    check_outs();
    chk("atten_now_o", 64'h0000_0000_0000_0000, atten_now_o);
    for (int a = 'h40; a <= 'h45; a++) rd_chk(7'(a));
  endtask : do_reset

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    void'($urandom(32'h4ea0));
    do_reset();
    $display("test reset_values done");
    for (int f = 0; f < 10; f++) begin
      wr(dfm_pkg::ADDR_FORMAT_POWERSAVE, {1'($urandom_range(1)), 3'b000, 4'(f)});
      check_outs();
      rd_chk(dfm_pkg::ADDR_FORMAT_POWERSAVE);
    end
    $display("test format_codes done");
    for (int i = 0; i < 24; i++) begin
      @(posedge clk_i);
      analog_mute_ctrl_on_disable_i <= 1'($urandom_range(1));
      wr(dfm_pkg::ADDR_FORMAT_POWERSAVE, {1'(i % 2), 3'b000, 4'($urandom_range(9))});
      wr(dfm_pkg::ADDR_OPERATION_FILTER, 8'($urandom()));
      wr(dfm_pkg::ADDR_OUTPUT_PHASE, 8'($urandom()));
      wr(dfm_pkg::ADDR_SOFT_MUTE, 8'($urandom()));
      check_outs();
      rd_chk(dfm_pkg::ADDR_OPERATION_FILTER);
      rd_chk(dfm_pkg::ADDR_OUTPUT_PHASE);
      rd_chk(dfm_pkg::ADDR_SOFT_MUTE);
    end
    $display("test operation_filter done");
    wr(dfm_pkg::ADDR_SOFT_MUTE, 8'h00);
    @(posedge clk_i);
    atten_level_i <= {$urandom(), $urandom()} | 64'hC0C0_C0C0_C0C0_C0C0;
    repeat (2) @(posedge clk_i);
    repeat (260) tick();
    wr(dfm_pkg::ADDR_SOFT_MUTE, 8'($urandom()));
    repeat (20) tick();
    wr(dfm_pkg::ADDR_SOFT_MUTE, 8'hFF);
    repeat (70) tick();
    wr(dfm_pkg::ADDR_SOFT_MUTE, 8'h00);
    repeat (70) tick();
    $display("test soft_mute_ramp done");
    do_reset();
    $display("test second_reset done");
    final_report();
  end
endmodule : dac_format_operation_mute_ctrl_test
